/* design/lpm_pkg.sv */
// Constants for the low-power mode and watchdog controller.
// Assumes one 125 MHz clock that also stands for the crystal oscillator clock.
package lpm_pkg;

  localparam int PRESCALE_W      = 12;
  localparam int WDOG_W          = 6;
  localparam int SERVICE_LO_BIT  = 4;
  localparam int POR_CYCLES      = 4096;
  localparam int WDOG_LONG_CYC   = 262128;
  localparam int WDOG_SHORT_CYC  = 8176;
  localparam int WDOG_PULSE_CYC  = 32;
  localparam int OSC_SETTLE_CYC  = 4096;
  localparam int WDOG_SHORT_TAP  = 7;
  localparam int RST_CNT_W       = 13;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP,
    MODE_SETTLE
  } lp_mode_t;

endpackage

/* design/low_power_mode_and_watchdog_ctrl.sv */
// Low-power mode sequencer with watchdog and prescale counter.
// Assumes the core pulses its wait/stop requests for one cycle and that
// every input is synchronous to i_clk, which stands for the oscillator clock.
`timescale 1ns/100ps
`default_nettype none

module low_power_mode_and_watchdog_ctrl #(
  parameter int POR_CYCLES     = lpm_pkg::POR_CYCLES,
  parameter int OSC_SETTLE_CYC = lpm_pkg::OSC_SETTLE_CYC,
  parameter int WDOG_PULSE_CYC = lpm_pkg::WDOG_PULSE_CYC,
  parameter logic [7:0] RESET_VECTOR_LO = 8'h00
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wait_instr,
  input  wire logic       i_stop_instr,
  input  wire logic       i_sei,
  input  wire logic       i_cli,
  input  wire logic       i_service_wr,
  input  wire logic       i_service_rd,
  input  wire logic       i_ext_irq,
  input  wire logic       i_spi_irq,
  input  wire logic       i_timer_irq,
  input  wire logic       i_pll_irq,
  input  wire logic       i_int_rst_src,
  input  wire logic       i_watchdog_en,
  input  wire logic       i_watchdog_rate_sel,
  input  wire logic       i_halt_enable,
  input  wire logic       i_osc_run_in_halt,
  input  wire logic       i_base_clock_select,
  input  wire logic       i_pll_power_on,
  input  wire logic       i_rst_flag_clr,
  output logic            o_cpu_clk_en,
  output logic            o_int_mask,
  output logic [7:0]      o_service_rdata,
  output logic            o_osc_en,
  output logic            o_pll_en,
  output logic            o_base_clock_sel,
  output logic            o_clockgen_out_en,
  output logic            o_spi_run,
  output logic            o_spi_rst,
  output logic            o_timer_run,
  output logic            o_rst_pin_n,
  output logic            o_wdog_flag,
  output logic [1:0]      o_mode
);

  localparam int PW = lpm_pkg::PRESCALE_W;
  localparam int WW = lpm_pkg::WDOG_W;
  localparam int CW = lpm_pkg::RST_CNT_W;
  localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(OSC_SETTLE_CYC - 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(WDOG_PULSE_CYC - 1);
  localparam logic [CW-1:0] PULSE_LEN = CW'(WDOG_PULSE_CYC);
  localparam logic [WW-1:0] WDOG_MAX = '1;
  localparam logic [PW-1:0] SVC_MASK =
    PW'(((1 << PW) - 1) & ~((1 << lpm_pkg::SERVICE_LO_BIT) - 1));

  lpm_pkg::lp_mode_t mode_reg;
  lpm_pkg::lp_mode_t mode_next;
  logic [PW-1:0] prescale_counter;
  logic [WW-1:0] watchdog_counter;
  logic [CW-1:0] seq_cnt_reg;
  logic          por_done_reg;
  logic          int_mask_reg;
  logic          rst_active_reg;
  logic [CW-1:0] rst_cnt_reg;
  logic          wdog_flag_reg;
  logic          spi_rst_reg;
  logic [CW-1:0] por_cnt_reg;
  logic [CW-1:0] pin_low_cnt_reg;

  // Decoded events.
  wire stop_ok    = i_stop_instr & i_halt_enable;
  wire in_stop    = (mode_reg == lpm_pkg::MODE_STOP);
  wire in_wait    = (mode_reg == lpm_pkg::MODE_WAIT);
  wire run_now    = (mode_reg == lpm_pkg::MODE_RUN);
  wire wait_wake  = i_ext_irq | i_spi_irq | i_timer_irq
                    | i_pll_irq;
  wire stop_wake  = i_ext_irq;
  wire pre_tick   = ~in_stop;
  wire wd_tap     = i_watchdog_rate_sel
                    ? (prescale_counter == '1)
                    : (prescale_counter[lpm_pkg::WDOG_SHORT_TAP-1:0] == '1);
  wire wd_tick    = pre_tick & wd_tap;
  wire wd_timeout = i_watchdog_en & wd_tick
                    & (watchdog_counter == WDOG_MAX);
  wire int_rst    = i_int_rst_src | wd_timeout;
  wire settle_end = (seq_cnt_reg == SETTLE_LAST);
  wire seq_por_end = (por_cnt_reg == POR_LAST);

  // Mode sequencing.
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      lpm_pkg::MODE_RUN:
        if (stop_ok)
          mode_next = lpm_pkg::MODE_STOP;
        else if (i_wait_instr)
          mode_next = lpm_pkg::MODE_WAIT;
      lpm_pkg::MODE_WAIT:
        if (wait_wake)
          mode_next = lpm_pkg::MODE_RUN;
      lpm_pkg::MODE_STOP:
        if (stop_wake)
          mode_next = lpm_pkg::MODE_SETTLE;
      lpm_pkg::MODE_SETTLE:
        if (settle_end)
          mode_next = lpm_pkg::MODE_RUN;
    endcase
    if (int_rst)
      mode_next = lpm_pkg::MODE_RUN;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      mode_reg <= lpm_pkg::MODE_RUN;
    else
      mode_reg <= mode_next;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || mode_reg != lpm_pkg::MODE_SETTLE)
      seq_cnt_reg <= '0;
    else
      seq_cnt_reg <= seq_cnt_reg + 1'b1;
  end

  // Prescale counter: cleared at the end of the power-on wait, counts in every mode except stop.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      prescale_counter <= '0;
    else if (int_rst || stop_ok && run_now)
      prescale_counter <= '0;
    else if (i_service_wr)
      prescale_counter <= prescale_counter & ~SVC_MASK;
    else if (!por_done_reg && seq_por_end)
      prescale_counter <= '0;
    else if (pre_tick)
      prescale_counter <= prescale_counter + 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end
    else if (!por_done_reg)
    begin
      por_cnt_reg  <= por_cnt_reg + 1'b1;
      por_done_reg <= seq_por_end;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || int_rst || i_service_wr)
      watchdog_counter <= '0;
    else if (wd_tick && i_watchdog_en)
      watchdog_counter <= watchdog_counter + 1'b1;
  end

  // Interrupt mask.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || int_rst)
      int_mask_reg <= 1'b1;
    else if (run_now && (stop_ok || i_wait_instr))
      int_mask_reg <= 1'b0;
    else if (i_sei)
      int_mask_reg <= 1'b1;
    else if (i_cli)
      int_mask_reg <= 1'b0;
  end

  // Watchdog reset pulse and cause flag.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rst_active_reg <= 1'b0;
      rst_cnt_reg    <= '0;
    end
    else if (wd_timeout)
    begin
      rst_active_reg <= 1'b1;
      rst_cnt_reg    <= '0;
    end
    else if (rst_active_reg)
    begin
      rst_cnt_reg    <= rst_cnt_reg + 1'b1;
      rst_active_reg <= (rst_cnt_reg != PULSE_LAST);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      wdog_flag_reg <= 1'b0;
    else if (wd_timeout)
      wdog_flag_reg <= 1'b1;
    else if (i_rst_flag_clr)
      wdog_flag_reg <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      spi_rst_reg <= 1'b1;
    else
      spi_rst_reg <= int_rst;
  end

  // Registered outputs.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_cpu_clk_en      <= 1'b1;
      o_osc_en          <= 1'b1;
      o_pll_en          <= 1'b0;
      o_base_clock_sel  <= 1'b0;
      o_clockgen_out_en <= 1'b1;
      o_spi_run         <= 1'b1;
      o_timer_run       <= 1'b1;
      o_service_rdata   <= '0;
    end
    else
    begin
      o_cpu_clk_en      <= (mode_next == lpm_pkg::MODE_RUN);
      o_osc_en          <= (mode_next != lpm_pkg::MODE_STOP)
                           | i_osc_run_in_halt;
      o_pll_en          <= i_pll_power_on
                           & (mode_next != lpm_pkg::MODE_STOP);
      o_base_clock_sel  <= i_base_clock_select & i_pll_power_on
                           & (mode_next != lpm_pkg::MODE_STOP);
      o_clockgen_out_en <= (mode_next != lpm_pkg::MODE_STOP)
                           | i_osc_run_in_halt;
      o_spi_run         <= (mode_next != lpm_pkg::MODE_STOP);
      o_timer_run       <= (mode_next != lpm_pkg::MODE_STOP);
      o_service_rdata   <= i_service_rd ? RESET_VECTOR_LO
                                        : o_service_rdata;
    end
  end

  assign o_int_mask  = int_mask_reg;
  assign o_rst_pin_n = ~rst_active_reg;
  assign o_wdog_flag = wdog_flag_reg;
  assign o_spi_rst   = spi_rst_reg;
  assign o_mode      = mode_reg;

  // Checks.
  property p_stop_gated;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_stop_instr && !i_halt_enable && run_now && !int_rst
      |=> mode_reg != lpm_pkg::MODE_STOP;
  endproperty
  a_stop_gated: assert property (p_stop_gated)
    else $error("stop taken with halt disabled");

  property p_stop_clears_mask;
    @(posedge i_clk) disable iff (!i_rst_n)
      run_now && stop_ok && !int_rst |=> !o_int_mask && !o_cpu_clk_en;
  endproperty
  a_stop_clears_mask: assert property (p_stop_clears_mask)
    else $error("stop did not clear mask");

  property p_wait_clears_mask;
    @(posedge i_clk) disable iff (!i_rst_n)
      run_now && i_wait_instr && !stop_ok && !int_rst
      |=> !o_int_mask && in_wait;
  endproperty
  a_wait_clears_mask: assert property (p_wait_clears_mask)
    else $error("wait did not clear mask");

  property p_reset_sets_mask;
    @(posedge i_clk) disable iff (!i_rst_n)
      int_rst |=> o_int_mask;
  endproperty
  a_reset_sets_mask: assert property (p_reset_sets_mask)
    else $error("internal reset left mask clear");

  property p_stop_ext_only;
    @(posedge i_clk) disable iff (!i_rst_n)
      in_stop && !i_ext_irq && !int_rst |=> in_stop;
  endproperty
  a_stop_ext_only: assert property (p_stop_ext_only)
    else $error("stop left without external interrupt");

  property p_service_clears;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_service_wr |=> watchdog_counter == '0;
  endproperty
  a_service_clears: assert property (p_service_clears)
    else $error("service write did not clear watchdog");

  property p_rst_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
      wd_timeout && !rst_active_reg |=> !o_rst_pin_n [*8] ##0 o_wdog_flag;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("watchdog reset pulse too short");

  // Counts the cycles the reset pin has been seen low, so that the whole
  // pulse length can be checked without a long repetition.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || o_rst_pin_n)
      pin_low_cnt_reg <= '0;
    else
      pin_low_cnt_reg <= pin_low_cnt_reg + 1'b1;
  end

  property p_rst_pulse_len;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_rst_pin_n) |-> pin_low_cnt_reg == PULSE_LEN;
  endproperty
  a_rst_pulse_len: assert property (p_rst_pulse_len)
    else $error("watchdog reset pulse length wrong");

  property p_settle_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      in_stop && i_ext_irq && !int_rst |=> !o_cpu_clk_en [*2];
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("cpu clock started before settle");

  property p_stop_freezes_prescale;
    @(posedge i_clk) disable iff (!i_rst_n)
      in_stop && $past(in_stop) && !i_service_wr && !int_rst
      |=> $stable(prescale_counter);
  endproperty
  a_stop_freezes_prescale: assert property (p_stop_freezes_prescale)
    else $error("prescale counted in stop");

  c_wait_wake: cover property (@(posedge i_clk) in_wait ##1 run_now);
  c_stop_wake: cover property (@(posedge i_clk)
    in_stop ##1 mode_reg == lpm_pkg::MODE_SETTLE);
  c_wdog_rst: cover property (@(posedge i_clk) wd_timeout);
  c_settle_done: cover property (@(posedge i_clk)
    mode_reg == lpm_pkg::MODE_SETTLE ##1 run_now);

endmodule

`default_nettype wire

/* dv/irq_source_model.sv */
// Model of the interrupt sources around the low-power controller.
// Assumes one clock; a fired request waits i_delay + 1 cycles, then holds
// its level for four cycles and drops.
`timescale 1ns/100ps
`default_nettype none

module irq_source_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_fire,
  input  wire logic [1:0] i_src,
  input  wire logic [7:0] i_delay,
  output logic            o_ext_irq,
  output logic            o_spi_irq,
  output logic            o_timer_irq
);
  logic [8:0] cnt_reg;
  logic [1:0] src_reg;
  logic       active;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cnt_reg <= 9'h000;
    else if (i_fire)
      cnt_reg <= {1'b0, i_delay} + 9'h005;
    else if (cnt_reg != 9'h000)
      cnt_reg <= cnt_reg - 9'h001;
    if (i_fire)
      src_reg <= i_src;
  end

  // Peripheral requests also arrive while stopped, where they must not wake.
  assign active      = (cnt_reg != 9'h000) && (cnt_reg < 9'h005);
  assign o_ext_irq   = active && (src_reg == 2'h0);
  assign o_spi_irq   = active && (src_reg == 2'h1);
  assign o_timer_irq = active && (src_reg == 2'h2);
endmodule

`default_nettype wire

/* dv/tb_low_power_mode_and_watchdog_ctrl.sv */
// Self-checking bench for the low-power mode and watchdog controller.
// Assumes the interrupt source model and a 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_low_power_mode_and_watchdog_ctrl;
  typedef struct packed {logic [18:0] care; logic [18:0] exp;} note_t;
  localparam int SETTLE = 16;
  localparam logic [7:0] VEC_LO = 8'ha5;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, chk = 1'b0;
  logic        i_watchdog_en = 1'b0, i_halt_enable = 1'b0;
  logic        i_osc_run_in_halt = 1'b0, i_base_clock_select = 1'b0;
  logic        i_pll_power_on = 1'b0, ext, spi, tim;
  logic [7:0]  pv = 8'h00, fdly = 8'h00;
  logic [1:0]  fsrc = 2'h0, o_mode;
  logic [31:0] rnd = 32'hebcf;
  logic        o_cpu_clk_en, o_int_mask, o_osc_en, o_pll_en, o_spi_rst;
  logic        o_clockgen_out_en, o_spi_run, o_timer_run, o_rst_pin_n;
  logic        o_wdog_flag, o_base_clock_sel;
  logic [7:0]  o_service_rdata;
  logic [18:0] obs;
  note_t       q[$];
  int          failures = 0, compares = 0, n;

  always #4 i_clk = ~i_clk;
  assign obs = {o_service_rdata, o_mode, o_int_mask, o_cpu_clk_en, o_osc_en,
                o_pll_en, o_clockgen_out_en, o_spi_run, o_timer_run,
                o_rst_pin_n, o_wdog_flag};

  low_power_mode_and_watchdog_ctrl #(.POR_CYCLES(16), .OSC_SETTLE_CYC(SETTLE),
    .RESET_VECTOR_LO(VEC_LO))
  dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wait_instr(pv[0]),
    .i_stop_instr(pv[1]), .i_sei(1'b0), .i_cli(pv[2]), .i_service_wr(pv[3]),
    .i_service_rd(pv[4]), .i_ext_irq(ext), .i_spi_irq(spi),
    .i_timer_irq(tim), .i_pll_irq(1'b0), .i_int_rst_src(pv[5]),
    .i_watchdog_en(i_watchdog_en), .i_watchdog_rate_sel(1'b0),
    .i_halt_enable(i_halt_enable), .i_osc_run_in_halt(i_osc_run_in_halt),
    .i_base_clock_select(i_base_clock_select),
    .i_pll_power_on(i_pll_power_on), .i_rst_flag_clr(pv[6]),
    .o_cpu_clk_en(o_cpu_clk_en), .o_int_mask(o_int_mask),
    .o_service_rdata(o_service_rdata), .o_osc_en(o_osc_en),
    .o_pll_en(o_pll_en), .o_base_clock_sel(o_base_clock_sel),
    .o_clockgen_out_en(o_clockgen_out_en), .o_spi_run(o_spi_run),
    .o_spi_rst(o_spi_rst), .o_timer_run(o_timer_run),
    .o_rst_pin_n(o_rst_pin_n), .o_wdog_flag(o_wdog_flag), .o_mode(o_mode));

  irq_source_model partner (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fire(pv[7]),
    .i_src(fsrc), .i_delay(fdly), .o_ext_irq(ext), .o_spi_irq(spi),
    .o_timer_irq(tim));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic pulse(input int k);
    pv[k] <= 1'b1;
    @(posedge i_clk);
    pv[k] <= 1'b0;
  endtask

  // The watcher compares the oldest note at the next falling edge.
  task automatic note(input logic [18:0] care, input logic [18:0] exp);
    q.push_back('{care, exp});
    chk <= 1'b1;
    @(posedge i_clk);
    chk <= 1'b0;
  endtask

  task automatic raise(input logic [1:0] src);
    rnd = xs(rnd);
    fsrc <= src;
    fdly <= {4'h0, rnd[3:0]};
    i_base_clock_select <= rnd[4];
    i_pll_power_on <= rnd[5];
    pulse(7);
  endtask

  task automatic run_while(input int k, input logic v, input int lim);
    n = 0;
    while (obs[k] === v)
    begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > lim)
      begin
        failures++;
        summarize();
      end
    end
  endtask

  task automatic cmp_n(input string what, input int lo, input int hi);
    compares++;
    if (n < lo || n > hi)
    begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask

  always @(negedge i_clk)
  begin
    if (chk === 1'b1)
    begin
      compares++;
      if ((obs & q[0].care) !== (q[0].exp & q[0].care))
      begin
        failures++;
        $display("[FAIL] outputs expected %h seen %h", q[0].exp & q[0].care,
                 obs & q[0].care);
      end
      void'(q.pop_front());
    end
  end

  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    note(19'h007df, 19'h001de);
    pulse(4);
    note(19'h7f800, {VEC_LO, 11'h000});
    pulse(2);
    pulse(1);
    note(19'h007df, 19'h000de);
    for (int s = 1; s < 3; s++)
    begin
      pulse(0);
      note(19'h007df, 19'h0025e);
      raise(s[1:0]);
      run_while(9, 1'b1, 100);
      note(19'h007df, 19'h000de);
      repeat (8) @(posedge i_clk);
    end
    i_halt_enable <= 1'b1;
    for (int o = 0; o < 2; o++)
    begin
      i_osc_run_in_halt <= o[0];
      pulse(1);
      note(o ? 19'h007ef : 19'h007ff,
           o ? 19'h00442 : 19'h00402);
      cmp_bit("clock select in stop", 1'b0, o_base_clock_sel);
      raise(2'h2);
      repeat (30) @(posedge i_clk);
      note(19'h00780, 19'h00400);
      raise(2'h0);
      run_while(9, 1'b0, 100);
      note(19'h00780, 19'h00600);
      run_while(7, 1'b0, 100);
      cmp_n("settle cycles", SETTLE - 1, SETTLE + 1);
      note(19'h007df, 19'h000de);
      @(negedge i_clk);
      cmp_bit("pll enable", i_pll_power_on, o_pll_en);
      cmp_bit("clock select", i_base_clock_select & i_pll_power_on,
              o_base_clock_sel);
      repeat (8) @(posedge i_clk);
    end
    pulse(1);
    pulse(5);
    n = 0;
    repeat (3) @(negedge i_clk) n += (o_spi_rst === 1'b1);
    cmp_n("spi reset cycles", 1, 2);
    @(posedge i_clk);
    note(19'h007df, 19'h001de);
    i_watchdog_en <= 1'b1;
    pulse(3);
    pulse(1);
    n = 0;
    repeat (8600) @(negedge i_clk) n += (o_rst_pin_n !== 1'b1);
    cmp_n("reset cycles in stop", 0, 0);
    @(posedge i_clk);
    raise(2'h0);
    run_while(7, 1'b0, 200);
    pulse(3);
    pulse(0);
    run_while(1, 1'b1, 9000);
    cmp_n("watchdog timeout", 8176, 8176 + 15);
    i_watchdog_en <= 1'b0;
    run_while(1, 1'b0, 100);
    cmp_n("reset pin low cycles", 32, 32);
    note(19'h007df, 19'h001df);
    pulse(6);
    note(19'h007df, 19'h001de);
    summarize();
  end
endmodule

`default_nettype wire
